// ==== hdl/dag_map.svh ====
// Notes on behaviour
// - post-modify by register: address is index, then index adds modify.
// - pre-modify by register: address is index plus modify, no write back.
// - post-modify by immediate: address is index, then index adds immediate.
// - pre-modify by immediate: address index plus immediate, no write back.
// - first generator uses index and modify registers 0 to 7 only.
// - second generator uses index and modify registers 8 to 15 only.
// - absolute direct address is the sequencer address field; no index register.
// - pc-relative address is program counter plus relative offset.
// - loop-abort on a taken branch pops loop stack and pc stack.
// - long-word qualifier forces long-word transfer in any address range.
`ifndef DAG_MAP_SVH
`define DAG_MAP_SVH
`define DAG_INDEX_RESET 32'h0000_0000
`define DAG_MODIFY_RESET 32'h0000_0000
`define DAG_REGS_PER_GEN 8
`define DAG_GEN2_BASE 4'h8
`endif

// ==== hdl/dag_pkg.sv ====
package dag_pkg;
   typedef enum logic [2:0] {
      DAG_OP_NONE,
      DAG_OP_POST_M,
      DAG_OP_PRE_M,
      DAG_OP_POST_IMM,
      DAG_OP_PRE_IMM,
      DAG_OP_ABS,
      DAG_OP_PCREL
   } dag_op_t;
endpackage : dag_pkg

// ==== hdl/dag_gen.sv ====
`timescale 1ns/1ps
`include "dag_map.svh"
// one address generator: eight index and eight modify registers
module dag_gen
   import dag_pkg::*;
#(
   parameter int AW = 32,
   parameter int IMMW = 8
) (
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            rst,
   // register load port
   input  wire logic            ld_index,
   input  wire logic            ld_modify,
   input  wire logic [2:0]      ld_sel,
   input  wire logic [AW-1:0]   ld_data,
   // request
   input  wire logic            req,
   input  wire dag_op_t         op,
   input  wire logic [2:0]      index_sel,
   input  wire logic [2:0]      modify_sel,
   input  wire logic [IMMW-1:0] imm,
   // result
   output logic [AW-1:0]        addr
);
   logic [AW-1:0] index_reg [`DAG_REGS_PER_GEN];
   logic [AW-1:0] modify_reg [`DAG_REGS_PER_GEN];

   wire logic [AW-1:0] idx_val = index_reg[index_sel];
   wire logic [AW-1:0] mod_val = modify_reg[modify_sel];
   wire logic [AW-1:0] imm_ext = {{(AW-IMMW){imm[IMMW-1]}}, imm};
   wire logic          use_imm = (op == DAG_OP_POST_IMM)
                               || (op == DAG_OP_PRE_IMM);
   wire logic [AW-1:0] offset  = use_imm ? imm_ext : mod_val;
   wire logic [AW-1:0] sum     = idx_val + offset;
   wire logic          pre     = (op == DAG_OP_PRE_M)
                               || (op == DAG_OP_PRE_IMM);
   wire logic          post    = req && ((op == DAG_OP_POST_M)
                               || (op == DAG_OP_POST_IMM));

   assign addr = pre ? sum : idx_val;

   genvar g;
   generate
      for (g = 0; g < `DAG_REGS_PER_GEN; g++) begin : g_regs
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               index_reg[g]  <= `DAG_INDEX_RESET;
               modify_reg[g] <= `DAG_MODIFY_RESET;
            end else begin
               if (post && index_sel == 3'(g))
                  index_reg[g] <= sum;
               else if (ld_index && ld_sel == 3'(g))
                  index_reg[g] <= ld_data;
               if (ld_modify && ld_sel == 3'(g))
                  modify_reg[g] <= ld_data;
            end
         end
      end
   endgenerate
endmodule : dag_gen

// ==== hdl/dag_top.sv ====
`timescale 1ns/1ps
`include "dag_map.svh"
module dag_top
   import dag_pkg::*;
#(
   parameter int AW   = 32,
   parameter int IMMW = 8
) (
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            rst,
   // register loads, 4-bit selects span both generators
   input  wire logic            ld_index,
   input  wire logic            ld_modify,
   input  wire logic [3:0]      ld_sel,
   input  wire logic [AW-1:0]   ld_data,
   // first generator request
   input  wire logic            gen1_req,
   input  wire dag_op_t         gen1_op,
   input  wire logic [2:0]      gen1_index_select,
   input  wire logic [2:0]      gen1_modify_select,
   input  wire logic [IMMW-1:0] gen1_imm,
   // second generator request
   input  wire logic            gen2_req,
   input  wire dag_op_t         gen2_op,
   input  wire logic [2:0]      gen2_index_select,
   input  wire logic [2:0]      gen2_modify_select,
   input  wire logic [IMMW-1:0] gen2_imm,
   input  wire logic            long_word_qualifier,
   // sequencer side
   input  wire logic            seq_req,
   input  wire dag_op_t         seq_op,
   input  wire logic [AW-1:0]   seq_addr_field,
   input  wire logic [AW-1:0]   pc,
   input  wire logic            branch_taken,
   input  wire logic            loop_abort_qualifier,
   // outputs
   output logic [AW-1:0]        dm_addr,
   output logic                 dm_valid,
   output logic [AW-1:0]        pm_addr,
   output logic                 pm_valid,
   output logic                 long_word,
   output logic [AW-1:0]        target_addr,
   output logic                 target_valid,
   output logic                 pop_loop_stack,
   output logic                 pop_pc_stack
);
   ////////////////////////////////////////////////////////////////////////
   wire logic          ld_gen2 = ld_sel[3];
   wire logic [AW-1:0] g1_addr;
   wire logic [AW-1:0] g2_addr;

   // first generator sees only selects 0..7
   dag_gen #(.AW(AW), .IMMW(IMMW)) u_gen1 (
      .mclk       (mclk),
      .rst        (rst),
      .ld_index   (ld_index && !ld_gen2),
      .ld_modify  (ld_modify && !ld_gen2),
      .ld_sel     (ld_sel[2:0]),
      .ld_data    (ld_data),
      .req        (gen1_req),
      .op         (gen1_op),
      .index_sel  (gen1_index_select),
      .modify_sel (gen1_modify_select),
      .imm        (gen1_imm),
      .addr       (g1_addr)
   );

   // second generator sees only selects 8..15
   dag_gen #(.AW(AW), .IMMW(IMMW)) u_gen2 (
      .mclk       (mclk),
      .rst        (rst),
      .ld_index   (ld_index && ld_gen2),
      .ld_modify  (ld_modify && ld_gen2),
      .ld_sel     (ld_sel[2:0]),
      .ld_data    (ld_data),
      .req        (gen2_req),
      .op         (gen2_op),
      .index_sel  (gen2_index_select),
      .modify_sel (gen2_modify_select),
      .imm        (gen2_imm),
      .addr       (g2_addr)
   );

   ////////////////////////////////////////////////////////////////////////
   wire logic          is_abs   = (seq_op == DAG_OP_ABS);
   wire logic          is_rel   = (seq_op == DAG_OP_PCREL);
   wire logic [AW-1:0] tgt_next = is_rel ? pc + seq_addr_field
                                         : seq_addr_field;
   wire logic          pop_next = branch_taken && loop_abort_qualifier;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dm_addr        <= '0;
         dm_valid       <= 1'b0;
         pm_addr        <= '0;
         pm_valid       <= 1'b0;
         long_word      <= 1'b0;
         target_addr    <= '0;
         target_valid   <= 1'b0;
         pop_loop_stack <= 1'b0;
         pop_pc_stack   <= 1'b0;
      end else begin
         dm_addr        <= g1_addr;
         dm_valid       <= gen1_req;
         pm_addr        <= g2_addr;
         pm_valid       <= gen2_req;
         long_word      <= long_word_qualifier;
         target_addr    <= tgt_next;
         target_valid   <= seq_req && (is_abs || is_rel);
         pop_loop_stack <= pop_next;
         pop_pc_stack   <= pop_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_pop_both;
      @(posedge mclk) disable iff (rst)
      (branch_taken && loop_abort_qualifier) |=>
         (pop_loop_stack && pop_pc_stack);
   endproperty
   a_pop_both: assert property (p_pop_both)
      else $error("loop abort did not pop both stacks");

   property p_no_pop;
      @(posedge mclk) disable iff (rst)
      !(branch_taken && loop_abort_qualifier) |=> !pop_pc_stack;
   endproperty
   a_no_pop: assert property (p_no_pop)
      else $error("pc stack popped without loop abort");

   property p_pcrel;
      @(posedge mclk) disable iff (rst)
      (seq_req && is_rel) |=>
         target_valid && target_addr == $past(pc) + $past(seq_addr_field);
   endproperty
   a_pcrel: assert property (p_pcrel)
      else $error("pc-relative target wrong");

   property p_abs;
      @(posedge mclk) disable iff (rst)
      (seq_req && is_abs) |=>
         target_valid && target_addr == $past(seq_addr_field);
   endproperty
   a_abs: assert property (p_abs)
      else $error("absolute target wrong");

   property p_long;
      @(posedge mclk) disable iff (rst)
      long_word_qualifier |=> long_word;
   endproperty
   a_long: assert property (p_long)
      else $error("long word not forced");

   ////////////////////////////////////////////////////////////////////////
   // generator checks read the register files directly, so a wrong select
   // or a lost write back shows even when the address itself looks sane
   property p_post_m;
      @(posedge mclk) disable iff (rst)
      (gen1_req && gen1_op == DAG_OP_POST_M) |=>
         dm_addr == $past(u_gen1.index_reg[gen1_index_select])
         && u_gen1.index_reg[$past(gen1_index_select)]
            == $past(u_gen1.index_reg[gen1_index_select])
               + $past(u_gen1.modify_reg[gen1_modify_select]);
   endproperty
   a_post_m: assert property (p_post_m)
      else $error("post-modify did not advance index");

   property p_pre_m;
      @(posedge mclk) disable iff (rst)
      (gen1_req && gen1_op == DAG_OP_PRE_M && !ld_index) |=>
         dm_addr == $past(u_gen1.index_reg[gen1_index_select])
                    + $past(u_gen1.modify_reg[gen1_modify_select])
         && u_gen1.index_reg[$past(gen1_index_select)]
            == $past(u_gen1.index_reg[gen1_index_select]);
   endproperty
   a_pre_m: assert property (p_pre_m)
      else $error("pre-modify address wrong or index written");

   property p_pre_imm;
      @(posedge mclk) disable iff (rst)
      (gen2_req && gen2_op == DAG_OP_PRE_IMM && !ld_index) |=>
         pm_addr == $past(u_gen2.index_reg[gen2_index_select])
                    + $past(AW'($signed(gen2_imm)))
         && u_gen2.index_reg[$past(gen2_index_select)]
            == $past(u_gen2.index_reg[gen2_index_select]);
   endproperty
   a_pre_imm: assert property (p_pre_imm)
      else $error("pre-modify immediate wrong or wrote back");

   property p_post_imm;
      @(posedge mclk) disable iff (rst)
      (gen2_req && gen2_op == DAG_OP_POST_IMM) |=>
         pm_addr == $past(u_gen2.index_reg[gen2_index_select])
         && u_gen2.index_reg[$past(gen2_index_select)]
            == $past(u_gen2.index_reg[gen2_index_select])
               + $past(AW'($signed(gen2_imm)));
   endproperty
   a_post_imm: assert property (p_post_imm)
      else $error("post-modify immediate wrong");

   property p_gen1_post_imm;
      @(posedge mclk) disable iff (rst)
      (gen1_req && gen1_op == DAG_OP_POST_IMM) |=>
         dm_addr == $past(u_gen1.index_reg[gen1_index_select])
         && u_gen1.index_reg[$past(gen1_index_select)]
            == $past(u_gen1.index_reg[gen1_index_select])
               + $past(AW'($signed(gen1_imm)));
   endproperty
   a_gen1_post_imm: assert property (p_gen1_post_imm)
      else $error("first generator post-modify immediate wrong");

   property p_gen1_pre_imm;
      @(posedge mclk) disable iff (rst)
      (gen1_req && gen1_op == DAG_OP_PRE_IMM && !ld_index) |=>
         dm_addr == $past(u_gen1.index_reg[gen1_index_select])
                    + $past(AW'($signed(gen1_imm)))
         && u_gen1.index_reg[$past(gen1_index_select)]
            == $past(u_gen1.index_reg[gen1_index_select]);
   endproperty
   a_gen1_pre_imm: assert property (p_gen1_pre_imm)
      else $error("first generator pre-modify immediate wrong");

   property p_gen2_post_m;
      @(posedge mclk) disable iff (rst)
      (gen2_req && gen2_op == DAG_OP_POST_M) |=>
         pm_addr == $past(u_gen2.index_reg[gen2_index_select])
         && u_gen2.index_reg[$past(gen2_index_select)]
            == $past(u_gen2.index_reg[gen2_index_select])
               + $past(u_gen2.modify_reg[gen2_modify_select]);
   endproperty
   a_gen2_post_m: assert property (p_gen2_post_m)
      else $error("second generator post-modify wrong");

   property p_gen2_pre_m;
      @(posedge mclk) disable iff (rst)
      (gen2_req && gen2_op == DAG_OP_PRE_M && !ld_index) |=>
         pm_addr == $past(u_gen2.index_reg[gen2_index_select])
                    + $past(u_gen2.modify_reg[gen2_modify_select])
         && u_gen2.index_reg[$past(gen2_index_select)]
            == $past(u_gen2.index_reg[gen2_index_select]);
   endproperty
   a_gen2_pre_m: assert property (p_gen2_pre_m)
      else $error("second generator pre-modify wrong");

   property p_dm_valid;
      @(posedge mclk) disable iff (rst)
      gen1_req |=> dm_valid;
   endproperty
   a_dm_valid: assert property (p_dm_valid)
      else $error("first generator request gave no data bus access");

   property p_dm_idle;
      @(posedge mclk) disable iff (rst)
      !gen1_req |=> !dm_valid;
   endproperty
   a_dm_idle: assert property (p_dm_idle)
      else $error("data bus access without a request");

   property p_pm_valid;
      @(posedge mclk) disable iff (rst)
      gen2_req |=> pm_valid;
   endproperty
   a_pm_valid: assert property (p_pm_valid)
      else $error("second generator request gave no program bus access");

   property p_pm_idle;
      @(posedge mclk) disable iff (rst)
      !gen2_req |=> !pm_valid;
   endproperty
   a_pm_idle: assert property (p_pm_idle)
      else $error("program bus access without a request");

   property p_gen1_iso;
      @(posedge mclk) disable iff (rst)
      (ld_index && ld_sel[3] && !gen1_req) |=>
         u_gen1.index_reg[$past(ld_sel[2:0])]
            == $past(u_gen1.index_reg[ld_sel[2:0]]);
   endproperty
   a_gen1_iso: assert property (p_gen1_iso)
      else $error("upper index load reached the first generator");

   property p_gen2_iso;
      @(posedge mclk) disable iff (rst)
      (ld_index && !ld_sel[3] && !gen2_req) |=>
         u_gen2.index_reg[$past(ld_sel[2:0])]
            == $past(u_gen2.index_reg[ld_sel[2:0]]);
   endproperty
   a_gen2_iso: assert property (p_gen2_iso)
      else $error("lower index load reached the second generator");

   property p_gen1_mod_ld;
      @(posedge mclk) disable iff (rst)
      (ld_modify && !ld_sel[3]) |=>
         u_gen1.modify_reg[$past(ld_sel[2:0])] == $past(ld_data);
   endproperty
   a_gen1_mod_ld: assert property (p_gen1_mod_ld)
      else $error("lower modify load missed the first generator");

   property p_gen2_mod_ld;
      @(posedge mclk) disable iff (rst)
      (ld_modify && ld_sel[3]) |=>
         u_gen2.modify_reg[$past(ld_sel[2:0])] == $past(ld_data);
   endproperty
   a_gen2_mod_ld: assert property (p_gen2_mod_ld)
      else $error("upper modify load missed the second generator");

   property p_no_loop_pop;
      @(posedge mclk) disable iff (rst)
      !(branch_taken && loop_abort_qualifier) |=> !pop_loop_stack;
   endproperty
   a_no_loop_pop: assert property (p_no_loop_pop)
      else $error("loop stack popped without loop abort");

   property p_target_idle;
      @(posedge mclk) disable iff (rst)
      !(seq_req && (is_abs || is_rel)) |=>
         !target_valid;
   endproperty
   a_target_idle: assert property (p_target_idle)
      else $error("target valid without a direct address request");

   property p_short;
      @(posedge mclk) disable iff (rst)
      !long_word_qualifier |=> !long_word;
   endproperty
   a_short: assert property (p_short)
      else $error("long word raised without qualifier");
endmodule : dag_top

// ==== testbench/dag_mem_model.sv ====
`timescale 1ns/1ps
// far-side bus model: counts accepted accesses on each memory bus
module dag_mem_model (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // memory bus strobes
   input  wire logic dm_valid,
   input  wire logic pm_valid,
   // access counts
   output int        dm_count,
   output int        pm_count
);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dm_count <= 0;
         pm_count <= 0;
      end else begin
         dm_count <= dm_count + int'(dm_valid === 1'b1);
         pm_count <= pm_count + int'(pm_valid === 1'b1);
      end
   end
endmodule : dag_mem_model

// ==== testbench/data_address_generator_tb.sv ====
`timescale 1ns/1ps
module data_address_generator_tb;
   import dag_pkg::*;
   typedef struct packed {
      logic [1:0]  kind;
      logic [31:0] val;
      logic        lw;
   } dag_note_t;
   logic        mclk = 1'b0;
   logic        rst;
   logic [5:0]  stb;
   logic [3:0]  ld_sel;
   logic [31:0] ld_data, fld, pcv, rv, dm_addr, pm_addr, target_addr;
   logic [31:0] ix [16];
   logic [31:0] mx [16];
   dag_op_t     op [2];
   dag_op_t     seq_op;
   logic [2:0]  isel [2];
   logic [2:0]  msel [2];
   logic [7:0]  imm [2];
   logic        lwq, laq, dm_valid, pm_valid, long_word, target_valid;
   logic        pop_loop_stack, pop_pc_stack;
   int          fail_count, n_compared, seed, dm_count, pm_count;
   int          nreq [2];
   dag_note_t   notes [$];
   always #5 mclk = ~mclk;
   dag_top u_dag_top (.mclk(mclk), .rst(rst), .ld_index(stb[5]),
      .ld_modify(stb[4]), .ld_sel(ld_sel), .ld_data(ld_data),
      .gen1_req(stb[3]), .gen1_op(op[0]), .gen1_index_select(isel[0]),
      .gen1_modify_select(msel[0]), .gen1_imm(imm[0]),
      .gen2_req(stb[2]), .gen2_op(op[1]), .gen2_index_select(isel[1]),
      .gen2_modify_select(msel[1]), .gen2_imm(imm[1]),
      .long_word_qualifier(lwq), .seq_req(stb[1]), .seq_op(seq_op),
      .seq_addr_field(fld), .pc(pcv), .branch_taken(stb[0]),
      .loop_abort_qualifier(laq), .dm_addr(dm_addr), .dm_valid(dm_valid),
      .pm_addr(pm_addr), .pm_valid(pm_valid), .long_word(long_word),
      .target_addr(target_addr), .target_valid(target_valid),
      .pop_loop_stack(pop_loop_stack), .pop_pc_stack(pop_pc_stack));
   dag_mem_model u_dag_mem_model (.mclk(mclk), .rst(rst),
      .dm_valid(dm_valid), .pm_valid(pm_valid), .dm_count(dm_count),
      .pm_count(pm_count));
   //////////////////////////////////////////////////
   task automatic ld(input logic m, input logic [3:0] s,
                     input logic [31:0] d);
      stb = m ? 6'h10 : 6'h20;
      ld_sel = s;
      ld_data = d;
      if (m) mx[s] = d;
      else ix[s] = d;
      @(negedge mclk);
   endtask : ld
   task automatic rq(input int g, input dag_op_t o, input logic [2:0] i,
                     input logic [2:0] m, input logic [7:0] v,
                     input logic lw);
      logic [3:0]  ri, rm;
      logic [31:0] a, off;
      ri = {g[0], i};
      rm = {g[0], m};
      off = (o == DAG_OP_POST_M || o == DAG_OP_PRE_M) ? mx[rm]
            : {{24{v[7]}}, v};
      a = (o == DAG_OP_PRE_M || o == DAG_OP_PRE_IMM) ? ix[ri] + off
          : ix[ri];
      if (o == DAG_OP_POST_M || o == DAG_OP_POST_IMM)
         ix[ri] = ix[ri] + off;
      notes.push_back('{2'(g), a, lw});
      nreq[g]++;
      stb = g[0] ? 6'h04 : 6'h08;
      op[g] = o;
      isel[g] = i;
      msel[g] = m;
      imm[g] = v;
      lwq = lw;
      @(negedge mclk);
   endtask : rq
   task automatic sq(input dag_op_t o, input logic [31:0] f, p);
      notes.push_back('{2'd2, (o == DAG_OP_ABS) ? f : p + f, 1'b0});
      stb = 6'h02;
      seq_op = o;
      fld = f;
      pcv = p;
      @(negedge mclk);
   endtask : sq
   task automatic br(input logic la);
      if (la) notes.push_back('{2'd3, 32'h0000_0003, 1'b0});
      stb = 6'h01;
      laq = la;
      @(negedge mclk);
   endtask : br
   task automatic chk(input logic [1:0] k, input logic [31:0] v,
                      input string nm);
      dag_note_t n;
      n_compared++;
      if (notes.size() > 0) n = notes.pop_front();
      else n = '{k, ~v, 1'b0};
      if (n.kind !== k || n.val !== v) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, n.val, v);
      end
      if (!k[1] && n.lw !== long_word) begin
         fail_count++;
         $display("[FAIL] long_word expected %b seen %b", n.lw, long_word);
      end
   endtask : chk
   task automatic complete_run;
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   //////////////////////////////////////////////////
   always @(negedge mclk) begin
      if (dm_valid === 1'b1) chk(2'd0, dm_addr, "dm_addr");
      if (pm_valid === 1'b1) chk(2'd1, pm_addr, "pm_addr");
      if (target_valid === 1'b1) chk(2'd2, target_addr, "target");
      if (pop_loop_stack === 1'b1 || pop_pc_stack === 1'b1)
         chk(2'd3, {30'h0, pop_loop_stack, pop_pc_stack}, "pops");
   end
   initial begin
      #20000;
      fail_count++;
      complete_run();
   end
   initial begin
      {stb, ld_sel, ld_data, fld, pcv, lwq, laq} = '0;
      op[0] = DAG_OP_NONE;
      op[1] = DAG_OP_NONE;
      seq_op = DAG_OP_NONE;
      {isel[0], isel[1], msel[0], msel[1], imm[0], imm[1]} = '0;
      {fail_count, n_compared, nreq[0], nreq[1]} = '0;
      seed = 18;
      for (int k = 0; k < 16; k++) {ix[k], mx[k]} = '0;
      rst = 1'b1;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      // index registers come out of reset at zero
      rq(0, DAG_OP_POST_M, 3'h0, 3'h0, 8'h00, 1'b0);
      for (int k = 0; k < 16; k++) begin
         ld(1'b0, 4'(k), $random(seed));
         ld(1'b1, 4'(k), $random(seed));
      end
      // back to back, alternating generators, so each generator is requested again two requests later, with random index selects
      for (int r = 0; r < 40; r++) begin
         rv = $random(seed);
         rq(r % 2, dag_op_t'(r % 5), rv[2:0], rv[5:3], rv[15:8],
            rv[16]);
      end
      for (int r = 0; r < 4; r++) begin
         rv = $random(seed);
         sq(r[0] ? DAG_OP_PCREL : DAG_OP_ABS, rv,
            {rv[15:0], rv[31:16]});
      end
      br(1'b1);
      br(1'b0);
      br(1'b1);
      stb = 6'h00;
      repeat (3) @(negedge mclk);
      n_compared++;
      if (dm_count !== nreq[0] || pm_count !== nreq[1]) begin
         fail_count++;
         $display("[FAIL] bus counts expected %0d %0d seen %0d %0d",
                  nreq[0], nreq[1], dm_count, pm_count);
      end
      if (notes.size() != 0) begin
         fail_count++;
         $display("[FAIL] pending notes expected 0 seen %0d", notes.size());
      end
      complete_run();
   end
endmodule : data_address_generator_tb
